// File: pkg/acs_pkg.sv
// Shared constants, field layouts and types of the converter sequencer.
// Assumes an 8-bit register port and a 10-bit successive-approximation core.
package acs_pkg;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] ADDR_CTRL_FIRST  = 8'h14;
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'h15;
    localparam logic [7:0] ADDR_RES_HIGH    = 8'h16;
    localparam logic [7:0] ADDR_RES_LOW     = 8'h17;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h19;
    localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h1a;
    localparam logic [7:0] REG_RESET        = 8'h00;

    // ********************************
    // Conversion clock selection
    // ********************************
    localparam logic [1:0] CLK_DIV8  = 2'h0;
    localparam logic [1:0] CLK_DIV32 = 2'h1;
    localparam logic [1:0] CLK_DIV64 = 2'h2;
    localparam logic [1:0] CLK_RC    = 2'h3;
    localparam int         DIV8      = 8;
    localparam int         DIV32     = 32;
    localparam int         DIV64     = 64;

    // ********************************
    // Sequencing counts
    // ********************************
    localparam int         RES_BITS   = 10;
    localparam logic [3:0] CONV_TICKS = 4'hc;
    localparam logic [3:0] SAR_TICKS  = 4'ha;
    localparam logic [3:0] WAIT_TICKS = 4'h2;
    localparam logic [2:0] INSTR_OSC  = 3'h4;
    localparam logic [9:0] SAR_FIRST  = 10'h200;
    localparam logic [5:0] PAD_ZERO   = 6'h00;

    // ********************************
    // Interrupt status layout
    // ********************************
    localparam int IRQ_W     = 2;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;

    // ********************************
    // Pin map: one bit per input, 1 = analog
    // ********************************
    localparam logic [11:0] PORT_MAP [8] = '{
        12'hfff, 12'hf7f, 12'hf3f, 12'hf1f,
        12'hf0f, 12'h707, 12'h303, 12'h000
    };

    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic [1:0] conv_clock_select;
        logic       result_justify;
        logic       unused;
        logic [2:0] port_analog_config;
        logic       reference_select;
    } acs_cfg_s;

    typedef struct packed {
        logic [3:0] channel;
        logic       unused_hi;
        logic       go;
        logic       unused_lo;
        logic       on;
    } acs_ctrl_s;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_ACQ,
        ST_DELAY,
        ST_CONV,
        ST_WAIT
    } acs_state_e;

endpackage

// File: rtl/acs_tick.sv
// Bit-time tick generator: oscillator divider or resynchronised RC clock.
// Assumes the RC clock is asynchronous to MCLK and slower than MCLK/4.
`timescale 1ns/100ps
module acs_tick (
    // Clock and reset
    input  wire logic       MCLK,
    input  wire logic       NRST,
    input  wire logic       CE,
    // Control
    input  wire logic [1:0] SEL,
    input  wire logic       RUN,
    input  wire logic       RC_CLK,
    // Tick
    output logic            TICK
);
    // ********************************
    // RC clock resynchroniser
    // ********************************
    logic [2:0] sync_q, sync_d;
    logic       level_q, level_d;
    logic [6:0] div_q, div_d;
    logic [6:0] ratio;

    always_comb begin
        sync_d  = {sync_q[1:0], RC_CLK};
        level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
        unique case (SEL)
            acs_pkg::CLK_DIV8:  ratio = 7'(acs_pkg::DIV8);
            acs_pkg::CLK_DIV32: ratio = 7'(acs_pkg::DIV32);
            default:            ratio = 7'(acs_pkg::DIV64);
        endcase
        // Divider restarts with each run so the first bit time is whole
        if (!RUN || div_q >= ratio - 7'h01) begin
            div_d = 7'h00;
        end else begin
            div_d = div_q + 7'h01;
        end
        if (SEL == acs_pkg::CLK_RC) begin
            TICK = RUN && level_d && !level_q;
        end else begin
            TICK = RUN && (div_q == ratio - 7'h01);
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            div_q   <= 7'h00;
        end else if (CE) begin
            sync_q  <= sync_d;
            level_q <= level_d;
            div_q   <= div_d;
        end
    end
endmodule // acs_tick

// File: rtl/acs_top.sv
// Converter sequencer: configuration registers, bit-time sequencing,
// result formatting and completion interrupt.
// Assumes an external analog core: a DAC driven by DAC_CODE and a
// comparator answering on COMP_IN within the same MCLK cycle.
`timescale 1ns/100ps
module acs_top (
    // Clock, reset, enable
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Analog core
    input  wire logic        RC_CLK,
    input  wire logic        COMP_IN,
    output logic      [9:0]  DAC_CODE,
    output logic      [3:0]  CHANNEL,
    output logic             SAMPLE_EN,
    output logic             REF_EXT,
    output logic      [11:0] ANALOG_MASK,
    // Interrupt
    output logic             IRQ
);
    // ********************************
    // Declarations
    // ********************************
    acs_pkg::acs_ctrl_s   ctrl_q, ctrl_d;
    acs_pkg::acs_cfg_s    cfg_q, cfg_d;
    logic [7:0]           res_hi_q, res_hi_d;
    logic [7:0]           res_lo_q, res_lo_d;
    logic [7:0]           rdata_q, rdata_d;
    logic [11:0]          mask_q, mask_d;
    logic [acs_pkg::IRQ_W-1:0] st_q, st_d;
    logic [acs_pkg::IRQ_W-1:0] en_q, en_d;
    logic [acs_pkg::IRQ_W-1:0] ev;
    logic                 irq_q, irq_d;
    acs_pkg::acs_state_e  state_q, state_d;
    logic [3:0]           cnt_q, cnt_d;
    logic [2:0]           dly_q, dly_d;
    logic [9:0]           sar_q, sar_d;
    logic [9:0]           trial_q, trial_d;
    logic                 tick;
    logic                 tick_run;
    logic                 wr_first, wr_second;
    logic                 done, abort;
    logic [9:0]           result;

    assign wr_first  = WR && ADDR == acs_pkg::ADDR_CTRL_FIRST;
    assign wr_second = WR && ADDR == acs_pkg::ADDR_CTRL_SECOND;

    // ********************************
    // Bit-time tick
    // ********************************
    // Divider restarts on abort so the wait is two whole bit times
    assign tick_run = (state_q == acs_pkg::ST_CONV && ctrl_q.go)
                   || state_q == acs_pkg::ST_WAIT;

    acs_tick u_tick (
        .MCLK   (MCLK),
        .NRST   (NRST),
        .CE     (CE),
        .SEL    (cfg_q.conv_clock_select),
        .RUN    (tick_run),
        .RC_CLK (RC_CLK),
        .TICK   (tick)
    );

    // ********************************
    // Sequencer
    // ********************************
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        dly_d   = dly_q;
        sar_d   = sar_q;
        trial_d = trial_q;
        done    = 1'b0;
        abort   = 1'b0;
        result  = sar_q;
        unique case (state_q)
            acs_pkg::ST_OFF: begin
                if (ctrl_q.on) begin
                    state_d = acs_pkg::ST_ACQ;
                end
            end
            acs_pkg::ST_ACQ: begin
                // Acquisition time is the caller's job; go starts at once
                if (ctrl_q.go) begin
                    cnt_d   = 4'h0;
                    dly_d   = 3'h0;
                    sar_d   = acs_pkg::SAR_FIRST;
                    trial_d = acs_pkg::SAR_FIRST;
                    if (cfg_q.conv_clock_select == acs_pkg::CLK_RC) begin
                        state_d = acs_pkg::ST_DELAY;
                    end else begin
                        state_d = acs_pkg::ST_CONV;
                    end
                end
            end
            acs_pkg::ST_DELAY: begin
                // Lets a sleep instruction land before the first bit time
                if (!ctrl_q.go) begin
                    abort   = 1'b1;
                    cnt_d   = 4'h0;
                    state_d = acs_pkg::ST_WAIT;
                end else if (dly_q == acs_pkg::INSTR_OSC - 3'h1) begin
                    state_d = acs_pkg::ST_CONV;
                end else begin
                    dly_d = dly_q + 3'h1;
                end
            end
            acs_pkg::ST_CONV: begin
                if (!ctrl_q.go) begin
                    // Partial code is dropped, result pair untouched
                    abort   = 1'b1;
                    cnt_d   = 4'h0;
                    state_d = acs_pkg::ST_WAIT;
                end else if (tick) begin
                    if (cnt_q < acs_pkg::SAR_TICKS) begin
                        if (!COMP_IN) begin
                            sar_d = sar_q & ~trial_q;
                        end
                        trial_d = trial_q >> 1;
                        sar_d   = sar_d | (trial_q >> 1);
                    end
                    if (cnt_q == acs_pkg::CONV_TICKS - 4'h1) begin
                        done    = 1'b1;
                        cnt_d   = 4'h0;
                        state_d = acs_pkg::ST_WAIT;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            acs_pkg::ST_WAIT: begin
                if (tick) begin
                    if (cnt_q == acs_pkg::WAIT_TICKS - 4'h1) begin
                        state_d = acs_pkg::ST_ACQ;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            default: begin
                state_d = acs_pkg::ST_OFF;
            end
        endcase
        if (!ctrl_q.on) begin
            state_d = acs_pkg::ST_OFF;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= acs_pkg::ST_OFF;
            cnt_q   <= 4'h0;
            dly_q   <= 3'h0;
            sar_q   <= 10'h000;
            trial_q <= 10'h000;
        end else if (CE) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            dly_q   <= dly_d;
            sar_q   <= sar_d;
            trial_q <= trial_d;
        end
    end

    // ********************************
    // Control and result registers
    // ********************************
    always_comb begin
        ctrl_d = ctrl_q;
        cfg_d  = cfg_q;
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        if (wr_first) begin
            ctrl_d    = acs_pkg::acs_ctrl_s'(WDATA);
            ctrl_d.unused_hi = 1'b0;
            ctrl_d.unused_lo = 1'b0;
            // Go is ignored in the write that turns the module on
            ctrl_d.go = WDATA[2] && ctrl_q.on && ctrl_d.on;
        end
        if (wr_second) begin
            cfg_d        = acs_pkg::acs_cfg_s'(WDATA);
            cfg_d.unused = 1'b0;
        end
        if (WR && ADDR == acs_pkg::ADDR_RES_HIGH) begin
            res_hi_d = WDATA;
        end
        if (WR && ADDR == acs_pkg::ADDR_RES_LOW) begin
            res_lo_d = WDATA;
        end
        if (done) begin
            ctrl_d.go = 1'b0;
            if (cfg_q.result_justify) begin
                res_hi_d = {acs_pkg::PAD_ZERO, result[9:8]};
                res_lo_d = result[7:0];
            end else begin
                res_hi_d = result[9:2];
                res_lo_d = {result[1:0], acs_pkg::PAD_ZERO};
            end
        end
        if (!ctrl_d.on) begin
            ctrl_d.go = 1'b0;
        end
        mask_d = acs_pkg::PORT_MAP[cfg_d.port_analog_config];
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q   <= acs_pkg::acs_ctrl_s'(acs_pkg::REG_RESET);
            cfg_q    <= acs_pkg::acs_cfg_s'(acs_pkg::REG_RESET);
            res_hi_q <= acs_pkg::REG_RESET;
            res_lo_q <= acs_pkg::REG_RESET;
            mask_q   <= acs_pkg::PORT_MAP[0];
        end else if (CE) begin
            ctrl_q   <= ctrl_d;
            cfg_q    <= cfg_d;
            res_hi_q <= res_hi_d;
            res_lo_q <= res_lo_d;
            mask_q   <= mask_d;
        end
    end

    // ********************************
    // Interrupt status
    // ********************************
    assign ev = {abort, done};

    always_comb begin
        st_d = st_q;
        en_d = en_q;
        if (WR && ADDR == acs_pkg::ADDR_IRQ_CLEAR) begin
            st_d = st_q & ~WDATA[acs_pkg::IRQ_W-1:0];
        end
        // A new event beats a clear in the same cycle
        st_d = st_d | ev;
        if (WR && ADDR == acs_pkg::ADDR_IRQ_ENABLE) begin
            en_d = WDATA[acs_pkg::IRQ_W-1:0];
        end
        irq_d = |(st_d & en_d);
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_q  <= '0;
            en_q  <= '0;
            irq_q <= 1'b0;
        end else if (CE) begin
            st_q  <= st_d;
            en_q  <= en_d;
            irq_q <= irq_d;
        end
    end

    // ********************************
    // Read port
    // ********************************
    always_comb begin
        rdata_d = acs_pkg::REG_RESET;
        if (RD) begin
            unique case (ADDR)
                acs_pkg::ADDR_CTRL_FIRST:  rdata_d = ctrl_q;
                acs_pkg::ADDR_CTRL_SECOND: rdata_d = cfg_q;
                acs_pkg::ADDR_RES_HIGH:    rdata_d = res_hi_q;
                acs_pkg::ADDR_RES_LOW:     rdata_d = res_lo_q;
                acs_pkg::ADDR_IRQ_STATUS: begin
                    rdata_d = 8'(st_q);
                end
                acs_pkg::ADDR_IRQ_ENABLE: begin
                    rdata_d = 8'(en_q);
                end
                default:                   rdata_d = acs_pkg::REG_RESET;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= acs_pkg::REG_RESET;
        end else if (CE) begin
            rdata_q <= rdata_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // No discharge path exists: the hold capacitor keeps its charge
    // and is only reconnected when acquisition restarts.
    assign SAMPLE_EN   = state_q == acs_pkg::ST_ACQ;
    assign DAC_CODE    = sar_q;
    assign CHANNEL     = ctrl_q.channel;
    assign REF_EXT     = cfg_q.reference_select;
    assign ANALOG_MASK = mask_q;
    assign RDATA       = rdata_q;
    assign IRQ         = irq_q;
endmodule // acs_top

// File: testbench/acs_analog_model.sv
// Analog side model: holding capacitor, comparator, RC oscillator.
// Assumes LEVEL is the code of the selected input, set by the bench.
`timescale 1ns/100ps
module acs_analog_model (
    // Converter side
    input  wire logic [9:0] DAC_CODE,
    input  wire logic       SAMPLE_EN,
    input  wire logic [9:0] LEVEL,
    // Answers
    output logic            COMP_IN,
    output logic            RC_CLK
);
    logic [9:0] held_q;

    // ************************
    // Behaviour
    // ************************
    // Free running, 2 us period keeps the bit time legal
    initial begin
        RC_CLK = 1'b0;
        forever #1000 RC_CLK = ~RC_CLK;
    end

    // Charge stays put while the switch is open
    initial held_q = 10'h000;
    always @(SAMPLE_EN or LEVEL) if (SAMPLE_EN) held_q = LEVEL;

    assign COMP_IN = (held_q >= DAC_CODE);
endmodule // acs_analog_model

// File: testbench/acs_top_assertions.sv
// Checker of the converter sequencer, bound to its top module.
// Assumes writes made while CE is low touch no shadowed register.
`timescale 1ns/100ps
module acs_top_assertions (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        NRST,
    // Register port
    input wire logic [7:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    // Analog side and interrupt
    input wire logic [3:0]  CHANNEL,
    input wire logic        SAMPLE_EN,
    input wire logic        REF_EXT,
    input wire logic [11:0] ANALOG_MASK,
    input wire logic        IRQ
);
    logic [7:0]  cfg_q;
    logic [10:0] low_q;
    logic        start_q;
    logic        wr_first;
    logic        wr_second;

    assign wr_first  = WR && (ADDR == acs_pkg::ADDR_CTRL_FIRST);
    assign wr_second = WR && (ADDR == acs_pkg::ADDR_CTRL_SECOND);

    // Shadow config and length of the isolated stretch
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cfg_q   <= 8'h00;
            low_q   <= 11'h000;
            start_q <= 1'b0;
        end else begin
            if (wr_second)
                cfg_q <= WDATA;
            low_q <= SAMPLE_EN ? 11'h000 : low_q + 11'h001;
            // Held to the first reacquire edge; abort or off drops it
            if (wr_first)
                start_q <= WDATA[2] && WDATA[0] && SAMPLE_EN;
            else if (SAMPLE_EN && low_q != 11'h000)
                start_q <= 1'b0;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // ************************
    // Properties
    // ************************
    sequence s_off_write;
        wr_first && !WDATA[0];
    endsequence
    sequence s_mask_write;
        WR && ADDR == acs_pkg::ADDR_IRQ_ENABLE && WDATA[1:0] == 2'h0;
    endsequence

    property p_cfg_readback;
        RD && ADDR == acs_pkg::ADDR_CTRL_SECOND |=> RDATA == (cfg_q & 8'hef);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("config readback wrong");
    property p_bit4_zero;
        RD && ADDR == acs_pkg::ADDR_CTRL_SECOND |=> !RDATA[4];
    endproperty
    a_bit4_zero: assert property (p_bit4_zero)
        else $error("unused config bit read as one");
    property p_port_map;
        wr_second |=> ANALOG_MASK == acs_pkg::PORT_MAP[$past(WDATA[3:1])];
    endproperty
    a_port_map: assert property (p_port_map)
        else $error("pin map wrong");
    property p_ref_sel;
        wr_second |=> REF_EXT == $past(WDATA[0]);
    endproperty
    a_ref_sel: assert property (p_ref_sel)
        else $error("reference select wrong");
    // Half a tick of slack against the start and end phase
    property p_min_low;
        $rose(SAMPLE_EN) && start_q |-> low_q >= 11'h06c;
    endproperty
    a_min_low: assert property (p_min_low)
        else $error("conversion plus wait too short");
    property p_irq_masked;
        s_mask_write |=> !IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt high while disabled");
    property p_off;
        s_off_write |-> ##2 !SAMPLE_EN;
    endproperty
    a_off: assert property (p_off)
        else $error("sampling while converter off");
    property p_channel;
        wr_first |=> CHANNEL == $past(WDATA[7:4]);
    endproperty
    a_channel: assert property (p_channel)
        else $error("channel select wrong");
endmodule // acs_top_assertions

bind acs_top acs_top_assertions acs_top_assertions_inst (
    .MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CHANNEL(CHANNEL), .SAMPLE_EN(SAMPLE_EN),
    .REF_EXT(REF_EXT), .ANALOG_MASK(ANALOG_MASK), .IRQ(IRQ));

// File: testbench/testbench.sv
// Self-checking bench of the converter sequencer with its analog side.
// Assumes the checker is bound to the top module on its own.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    localparam logic [7:0] A_C0 = acs_pkg::ADDR_CTRL_FIRST;
    localparam logic [7:0] A_C1 = acs_pkg::ADDR_CTRL_SECOND;
    localparam logic [7:0] A_HI = acs_pkg::ADDR_RES_HIGH;
    localparam logic [7:0] A_LO = acs_pkg::ADDR_RES_LOW;
    localparam logic [7:0] A_ST = acs_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] A_CL = acs_pkg::ADDR_IRQ_CLEAR;
    localparam logic [7:0] A_EN = acs_pkg::ADDR_IRQ_ENABLE;
    logic        mclk, nrst, ce, wr, rd, comp, rc_clk, smp, ref_ext, irq;
    logic [7:0]  addr, wdata, rdata;
    logic [9:0]  dac, level;
    logic [3:0]  chan;
    logic [11:0] amask;
    int          mismatches = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [11:0] pmap [8] = '{12'hfff, 12'hf7f, 12'hf3f, 12'hf1f,
                              12'hf0f, 12'h707, 12'h303, 12'h000};
    int          divs [4] = '{8, 32, 64, 100};
    logic [9:0]  vals [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};

    acs_top acs_top_inst (.MCLK(mclk), .NRST(nrst), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RC_CLK(rc_clk),
        .COMP_IN(comp), .DAC_CODE(dac), .CHANNEL(chan), .SAMPLE_EN(smp),
        .REF_EXT(ref_ext), .ANALOG_MASK(amask), .IRQ(irq));
    acs_analog_model acs_analog_model_inst (.DAC_CODE(dac),
        .SAMPLE_EN(smp), .LEVEL(level), .COMP_IN(comp), .RC_CLK(rc_clk));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    // ************************
    // Bus and check tasks
    // ************************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] a,
                           input logic [7:0] e);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 `CHK(nm, e, rdata)
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ************************
    // Scenarios
    // ************************
    task automatic t_reset();
        for (int a = 8'h14; a <= 8'h1a; a++)
            chk_reg("reset_value", a[7:0], 8'h00);
        `CHK("reset_mask", 12'hfff, amask)
        wr_reg(8'h30, 8'hff);
        chk_reg("unmapped", 8'h30, 8'h00);
        wr_reg(A_C0, 8'h00);
        // Writes are dropped while the clock enable is low
        ce <= 1'b0;
        wr_reg(A_EN, 8'h01);
        ce <= 1'b1;
        chk_reg("ce_frozen", A_EN, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_config();
        logic [7:0] d;
        for (int k = 0; k < 8; k++) begin
            d = {k[1:0], k[0], 1'b1, k[2:0], k[0]};
            wr_reg(A_C1, d);
            wait_clk(2);
            `CHK("port_map", pmap[k], amask)
            `CHK("ref_select", k[0], ref_ext)
            chk_reg("cfg_read", A_C1, d & 8'hef);
        end
        $display("test config done");
    endtask

    task automatic t_convert(input int k);
        logic [9:0] v;
        int         dv;
        int         lo;
        int         t0;
        v  = vals[k];
        dv = divs[k];
        lo = (k == 3) ? dv : 0;
        level <= v;
        // The RC pass stands for a conversion run from sleep
        wr_reg(A_C1, {k[1:0], ~k[0], 5'h00});
        wr_reg(A_EN, 8'h00);
        wr_reg(A_C0, {k[3:0], 4'h1});
        wait_clk(8);
        wr_reg(A_C0, {k[3:0], 4'h5});
        t0 = cyc;
        // Sampling stops one edge after go lands
        wait_clk(2);
        `CHK("conv_isolated", 1'b0, smp)
        while (smp === 1'b0 && cyc - t0 < 16 * dv)
            wait_clk(1);
        // Twelve conversion and two wait bit times, go to reacquire
        `CHK("conv_min", 1'b1, cyc - t0 >= 14 * dv - lo)
        `CHK("conv_max", 1'b1, cyc - t0 <= 14 * dv + 2 + lo)
        chk_reg("go_clear", A_C0, {k[3:0], 4'h1});
        if (k[0] == 1'b0) begin
            chk_reg("res_high", A_HI, {6'h00, v[9:8]});
            chk_reg("res_low", A_LO, v[7:0]);
        end else begin
            chk_reg("res_high", A_HI, v[9:2]);
            chk_reg("res_low", A_LO, {v[1:0], 6'h00});
        end
        chk_reg("done_flag", A_ST, 8'h01);
        `CHK("irq_masked", 1'b0, irq)
        wr_reg(A_EN, 8'h01);
        wait_clk(2);
        `CHK("irq_set", 1'b1, irq)
        wr_reg(A_CL, 8'h01);
        wait_clk(2);
        `CHK("irq_clear", 1'b0, irq)
        $display("test convert %0d done", k);
    endtask

    task automatic t_abort();
        level <= 10'h155;
        wr_reg(A_C1, 8'h80);
        wr_reg(A_HI, 8'ha5);
        wr_reg(A_LO, 8'h3c);
        wr_reg(A_C0, 8'h21);
        wait_clk(8);
        wr_reg(A_C0, 8'h25);
        wait_clk(100);
        wr_reg(A_C0, 8'h21);
        wait_clk(2);
        `CHK("abort_isolated", 1'b0, smp)
        chk_reg("keep_high", A_HI, 8'ha5);
        chk_reg("keep_low", A_LO, 8'h3c);
        wr_reg(A_ST, 8'hff);
        chk_reg("abort_flag", A_ST, 8'h02);
        wr_reg(A_CL, 8'hff);
        chk_reg("flag_clear", A_ST, 8'h00);
        wr_reg(A_C0, 8'h00);
        $display("test abort done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        nrst  = 1'b0;
        ce    = 1'b1;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 8'h00;
        wdata = 8'h00;
        level = 10'h000;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_config();
        for (int k = 0; k < 4; k++)
            t_convert(k);
        t_abort();
        give_verdict();
    end

    // About twelve times the expected run length
    initial begin
        #(40000 * 20);
        mismatches++;
        give_verdict();
    end
endmodule // testbench
